// File: logic/gated_pulse_counter_display.sv
// Purpose: Gated pulse counter with decimal display and AXI4-Lite access.
// Assumes: aclk is the 100 MHz crystal reference; pins are asynchronous.
// Notes:   Gate lengths are parameters so a bench can shorten them.
//
// How it works
// - Pulses are counted over a 1 s or 10 s gate picked by a switch.
// - The gate is an exact count of crystal clock cycles.
// - The result is four decimal digits, at most 9999.
// - A count beyond four digits lights the overflow indicator.
// - Each gate end posts the result and briefly flashes that indicator.
// - Each input pulse is echoed as a positive 25 us output pulse.
// - A gate with no pulses shows a blank display.
// - A low battery input lights the battery indicator.
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
module gated_pulse_counter_display
  import gpc_pkg::*;
#(
  parameter int unsigned SHORT_CYC = gpc_pkg::GATE_SHORT_CYC,
  parameter int unsigned LONG_CYC  = gpc_pkg::GATE_LONG_CYC,
  parameter int unsigned FLASH_LEN = gpc_pkg::FLASH_CYC
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Front panel and converter pins
  input  wire logic                  pulse_in,
  input  wire logic                  long_sel_in,
  input  wire logic                  bat_low_in,
  // Display and indicators
  output logic [gpc_pkg::DISP_W-1:0] disp_digits,
  output logic                       disp_blank,
  output logic                       ovf_led,
  output logic                       bat_led,
  output logic                       pulse_echo,
  output logic                       irq,
  // AXI4-Lite write
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  import gpc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync_r [3];
  logic [2:0] pin_r;
  logic [2:0] pins;

  assign pins = {bat_low_in, long_sel_in, pulse_in};

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync_r[p] <= 3'h0;
          pin_r[p]  <= 1'b0;
        end else begin
          sync_r[p] <= {sync_r[p][1:0], pins[p]};
          if (sync_r[p][2] == sync_r[p][1]) begin
            pin_r[p] <= sync_r[p][2];
          end
        end
      end
    end
  endgenerate

  logic pulse_q_r;
  logic pulse_rise;
  logic bat_q_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_q_r <= 1'b0;
      bat_q_r   <= 1'b0;
    end else begin
      pulse_q_r <= pin_r[0];
      bat_q_r   <= pin_r[2];
    end
  end

  assign pulse_rise = pin_r[0] & ~pulse_q_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0]       ctrl_r;
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic [DISP_W-1:0] result_r;
  logic             result_ovf_r;
  logic             long_r;

  // ----------------------------------------------------------------
  // Gate timer
  // ----------------------------------------------------------------
  logic [31:0] gate_cnt_r;
  logic [31:0] gate_len;
  logic        gate_end;
  logic        want_long;

  assign want_long = ctrl_r[CTRL_OVRIDE] ? ctrl_r[CTRL_LONG] : pin_r[1];
  assign gate_len  = long_r ? LONG_CYC : SHORT_CYC;
  assign gate_end  = ctrl_r[CTRL_RUN] && (gate_cnt_r == gate_len - 32'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_cnt_r <= 32'h0;
    end else if (!ctrl_r[CTRL_RUN] || gate_end) begin
      gate_cnt_r <= 32'h0;
    end else begin
      gate_cnt_r <= gate_cnt_r + 32'h1;
    end
  end

  // Gate length only changes between gates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      long_r <= 1'b0;
    end else if (!ctrl_r[CTRL_RUN] || gate_end) begin
      long_r <= want_long;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  cnt_if #(.DW(DISP_W)) acc ();

  assign acc.clr = gate_end || !ctrl_r[CTRL_RUN];
  assign acc.inc = pulse_rise && ctrl_r[CTRL_RUN];

  bcd_counter #(.DIGITS(DIGITS)) u_acc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (acc)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_r     <= '0;
      result_ovf_r <= 1'b0;
    end else if (gate_end) begin
      result_r     <= acc.digits;
      result_ovf_r <= acc.ovf;
    end
  end

  // ----------------------------------------------------------------
  // Display and indicators
  // ----------------------------------------------------------------
  logic [31:0] flash_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_r <= 32'h0;
    end else if (gate_end) begin
      flash_r <= FLASH_LEN;
    end else if (flash_r != 32'h0) begin
      flash_r <= flash_r - 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp_digits <= '0;
      disp_blank  <= 1'b1;
      ovf_led     <= 1'b0;
      bat_led     <= 1'b0;
    end else begin
      disp_digits <= result_r;
      disp_blank  <= (result_r == '0) && !result_ovf_r;
      ovf_led     <= result_ovf_r ^ (flash_r != 32'h0);
      bat_led     <= pin_r[2];
    end
  end

  // ----------------------------------------------------------------
  // Pulse echo
  // ----------------------------------------------------------------
  logic [11:0] echo_r;

  // Input at most 10 kHz, so an echo ends before the next pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      echo_r     <= 12'h0;
      pulse_echo <= 1'b0;
    end else begin
      if (pulse_rise) begin
        echo_r <= 12'(ECHO_CYC);
      end else if (echo_r != 12'h0) begin
        echo_r <= echo_r - 12'h1;
      end
      pulse_echo <= pulse_rise || (echo_r > 12'h1);
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_st_nxt;

  assign irq_set    = {pin_r[2] & ~bat_q_r, gate_end & acc.ovf, gate_end};
  assign irq_st_nxt = (irq_st_r & ~irq_clr) | irq_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_r <= '0;
      irq      <= 1'b0;
    end else begin
      irq_st_r <= irq_st_nxt;
      irq      <= |(irq_st_nxt & irq_en_r);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic        do_write;
  logic        wr_hit;

  assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_hit   = (aw_addr_r[7:2] == OFS_CTRL[7:2]) ||
                    (aw_addr_r[7:2] == OFS_IRQ_CLR[7:2]) ||
                    (aw_addr_r[7:2] == OFS_IRQ_EN[7:2]);
  assign irq_clr  = (do_write && aw_addr_r[7:2] == OFS_IRQ_CLR[7:2] &&
                     w_strb_r[0]) ? w_data_r[IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 8'h0;
      w_data_r      <= 32'h0;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_got_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_got_r      <= 1'b0;
        w_got_r       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= CTRL_RESET;
      irq_en_r <= '0;
    end else if (do_write && w_strb_r[0]) begin
      if (aw_addr_r[7:2] == OFS_CTRL[7:2]) begin
        ctrl_r <= w_data_r[2:0];
      end
      if (aw_addr_r[7:2] == OFS_IRQ_EN[7:2]) begin
        irq_en_r <= w_data_r[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic        rd_hit;

  always_comb begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr[7:2])
      OFS_CTRL[7:2]:   rd_val = {29'h0, ctrl_r};
      OFS_STATUS[7:2]: rd_val = {28'h0, long_r, disp_blank,
                                 pin_r[2], result_ovf_r};
      OFS_RESULT[7:2]: rd_val = {15'h0, result_ovf_r, result_r};
      OFS_LIVE[7:2]:   rd_val = {15'h0, acc.ovf, acc.digits};
      OFS_IRQ_ST[7:2]: rd_val = {29'h0, irq_st_r};
      OFS_IRQ_CLR[7:2]: rd_val = 32'h0;
      OFS_IRQ_EN[7:2]: rd_val = {29'h0, irq_en_r};
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// File: logic/gpc_pkg.sv
// Purpose: Shared constants for the gated pulse counter.
// Assumes: 100 MHz crystal clock on aclk.
// Notes:   Byte offsets of the AXI4-Lite register map.
package gpc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned GATE_SHORT_S = 1;
  localparam int unsigned GATE_LONG_S  = 10;
  localparam int unsigned GATE_SHORT_CYC = CLK_HZ * GATE_SHORT_S;
  localparam int unsigned GATE_LONG_CYC  = CLK_HZ * GATE_LONG_S;
  localparam int unsigned ECHO_US     = 25;
  localparam int unsigned ECHO_CYC    = (ECHO_US * (CLK_HZ / 1_000_000));
  localparam int unsigned FLASH_MS    = 50;
  localparam int unsigned FLASH_CYC   = FLASH_MS * (CLK_HZ / 1_000);

  // ----------------------------------------------------------------
  // Display
  // ----------------------------------------------------------------
  localparam int unsigned DIGITS      = 4;
  localparam int unsigned DISP_W      = 4 * DIGITS;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_RESULT  = 8'h08;
  localparam logic [7:0] OFS_LIVE    = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h18;

  // CTRL fields
  localparam int unsigned CTRL_RUN     = 0;
  localparam int unsigned CTRL_OVRIDE  = 1;
  localparam int unsigned CTRL_LONG    = 2;
  localparam logic [2:0]  CTRL_RESET   = 3'h1;

  // STATUS fields
  localparam int unsigned ST_OVF       = 0;
  localparam int unsigned ST_BATLOW    = 1;
  localparam int unsigned ST_BLANK     = 2;
  localparam int unsigned ST_LONG      = 3;

  // Interrupt fields
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_DONE     = 0;
  localparam int unsigned IRQ_OVF      = 1;
  localparam int unsigned IRQ_BAT      = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: logic/cnt_if.sv
// Purpose: Link between the gate control and the decimal accumulator.
// Assumes: Single clock domain.
// Notes:   clr with inc restarts the count at one.
interface cnt_if #(parameter int unsigned DW = 16);
  logic          clr;
  logic          inc;
  logic [DW-1:0] digits;
  logic          ovf;
  modport ctl (output clr, output inc, input digits, input ovf);
  modport cnt (input clr, input inc, output digits, output ovf);
endinterface

// File: logic/bcd_counter.sv
// Purpose: Saturating decimal accumulator, one nibble per digit.
// Assumes: inc is a one-cycle pulse from the same clock.
// Notes:   Holds at all nines and raises ovf until cleared.
module bcd_counter #(
  parameter int unsigned DIGITS = 4
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control side
  cnt_if.cnt        bus
);
  localparam logic [3:0] NINE = 4'h9;

  logic [4*DIGITS-1:0] cnt_r;
  logic [4*DIGITS-1:0] cnt_nxt;
  logic [DIGITS:0]     carry;
  logic                ovf_r;
  logic                full;

  assign carry[0] = 1'b1;

  // ----------------------------------------------------------------
  // Per-digit carry chain
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_dig
      logic [3:0] d;
      assign d = cnt_r[4*g +: 4];
      assign carry[g+1] = carry[g] & (d == NINE);
      assign cnt_nxt[4*g +: 4] = !carry[g] ? d :
                                 (d == NINE) ? 4'h0 : d + 4'h1;
    end
  endgenerate

  assign full = carry[DIGITS];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else if (bus.clr) begin
      cnt_r <= {{(4*DIGITS-1){1'b0}}, bus.inc};
    end else if (bus.inc && !full) begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_r <= 1'b0;
    end else if (bus.clr) begin
      ovf_r <= 1'b0;
    end else if (bus.inc && full) begin
      ovf_r <= 1'b1;
    end
  end

  assign bus.digits = cnt_r;
  assign bus.ovf    = ovf_r;
endmodule

// File: tb/vfc_model.sv
// Purpose: Converter model, a burst of pulses on request.
// Assumes: Driven from the bench clock domain.
// Notes:   Low half then high half per pulse; idles low.
module vfc_model (
  // Clock
  input  wire logic        aclk,
  // Request
  input  wire logic        go,
  input  wire logic [15:0] n_pulses,
  input  wire logic [15:0] half_cyc,
  // Converter pin
  output logic             pulse,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] left_r;
  logic [15:0] tmr_r;

  initial begin
    left_r = 16'h0000;
    tmr_r  = 16'h0000;
    pulse  = 1'b0;
  end

  // ----------------------------------------------------------------
  // Pulse train, rate set by half_cyc; 16'h1388 gives 10 kHz
  // ----------------------------------------------------------------
  // Plain always: the start values come from the initial block
  always @(posedge aclk) begin
    if (go) begin
      left_r <= n_pulses;
      tmr_r  <= 16'h0000;
      pulse  <= 1'b0;
    end else if (left_r != 16'h0000) begin
      if (tmr_r == half_cyc - 16'h0001) begin
        tmr_r <= 16'h0000;
        pulse <= !pulse;
        if (pulse) begin
          left_r <= left_r - 16'h0001;
        end
      end else begin
        tmr_r <= tmr_r + 16'h0001;
      end
    end
  end

  assign busy = (left_r != 16'h0000);
endmodule

// File: tb/gpc_props.sv
// Purpose: Port-level checks on the gated pulse counter.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Bound into every instance of the top module.
module gpc_props
  import gpc_pkg::*;
#(
  parameter int unsigned SHORT_CYC = 200
) (
  // Clock and reset
  input wire logic                        aclk,
  input wire logic                        aresetn,
  // Pins
  input wire logic                        pulse_in,
  input wire logic                        bat_low_in,
  input wire logic [gpc_pkg::DISP_W-1:0]  disp_digits,
  input wire logic                        disp_blank,
  input wire logic                        bat_led,
  input wire logic                        pulse_echo,
  // Bus handshakes
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned GAP_MIN = SHORT_CYC - 2;
  int unsigned echo_r;
  int unsigned gap_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !pulse_echo) echo_r <= 0;
    else echo_r <= echo_r + 1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || $changed(disp_digits)) gap_r <= 0;
    else gap_r <= gap_r + 1;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid) else $error("rvalid dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_echo_start: assert property ($rose(pulse_in) |->
    ##[1:8] pulse_echo) else $error("echo did not start");
  a_echo_width: assert property ($fell(pulse_echo) |->
    echo_r >= ECHO_CYC) else $error("echo too short");
  a_blank_zero: assert property (disp_blank |->
    disp_digits == 16'h0000) else $error("blank with digits");
  a_digit_bcd: assert property (disp_digits[3:0] <= 4'h9 &&
    disp_digits[7:4] <= 4'h9 && disp_digits[11:8] <= 4'h9 &&
    disp_digits[15:12] <= 4'h9) else $error("digit above nine");
  a_bat_follow: assert property ($rose(bat_low_in) |->
    ##[1:8] bat_led) else $error("battery led late");
  a_post_gap: assert property ($changed(disp_digits) |->
    gap_r >= GAP_MIN) else $error("result posted mid gate");

  c_blank: cover property ($rose(disp_blank));
  c_echo: cover property ($fell(pulse_echo));
  c_bat: cover property ($rose(bat_led));
  c_full: cover property (disp_digits == 16'h9999);
endmodule

bind gated_pulse_counter_display gpc_props #(.SHORT_CYC(SHORT_CYC)) chk_u (
  .aclk, .aresetn, .pulse_in, .bat_low_in, .disp_digits, .disp_blank,
  .bat_led, .pulse_echo, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready
);

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the gated pulse counter.
// Assumes: Short gates via parameters; 10 ns clock.
// Notes:   Fast pulse bursts stand in for long real gates.
`define CHK(a, b) begin \
  tests_run++; \
  if ((a) !== (b)) begin \
    bad_count++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gpc_pkg::*;
  localparam int unsigned SC = 600;
  localparam int unsigned LC = 81000;
  typedef struct { logic [15:0] n; logic [15:0] dig; logic blank; } row_t;
  row_t rows [4] = '{'{16'd12, 16'h0012, 1'b0}, '{16'd59, 16'h0059, 1'b0},
                     '{16'd0, 16'h0000, 1'b1}, '{16'd1, 16'h0001, 1'b0}};
  logic aclk = 0, aresetn = 0, long_sel_in = 0, bat_low_in = 0, pulse_in;
  logic [15:0] disp_digits;
  logic disp_blank, ovf_led, bat_led, pulse_echo, irq, vbusy, flash_v;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, st, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, go = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] vn = 0, vh = 16'h4;
  int tests_run = 0, bad_count = 0, k, run = 0, last_w = 0;
  time gap, t_last = 0;

  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (pulse_echo) run <= run + 1;
    else begin
      if (run != 0) last_w <= run;
      run <= 0;
    end
  end

  gated_pulse_counter_display #(.SHORT_CYC(SC), .LONG_CYC(LC),
    .FLASH_LEN(20)) dut_u (.aclk, .aresetn, .pulse_in, .long_sel_in,
    .bat_low_in, .disp_digits, .disp_blank, .ovf_led, .bat_led,
    .pulse_echo, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  vfc_model pm_u (.aclk, .go, .n_pulses(vn), .half_cyc(vh),
    .pulse(pulse_in), .busy(vbusy));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic guard(int n, int lim);
    if (n >= lim) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axi_wr(logic [7:0] a, logic [31:0] v, output logic [1:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Ready raised once valid is seen, so the slave must hold its answer
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && s_axi_bready !== 1'b1)
        s_axi_bready <= 1'b1;
    end while ((s_axi_bvalid & s_axi_bready) !== 1'b1 && n < 100);
    guard(n, 100);
    e = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1)
        s_axi_rready <= 1'b1;
    end while ((s_axi_rvalid & s_axi_rready) !== 1'b1 && n < 100);
    guard(n, 100);
    v = s_axi_rdata;
    e = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_done(int lim);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (irq !== 1'b1 && n < lim);
    guard(n, lim);
    gap = $time - t_last;
    t_last = $time;
    // Flash reaches the pin one edge after the post
    @(posedge aclk);
    flash_v = ovf_led;
    axi_rd(OFS_IRQ_ST, st, r);
    axi_wr(OFS_IRQ_CLR, 32'h7, r);
  endtask
  task automatic send(logic [15:0] cnt, logic [15:0] h);
    int n;
    n = 0;
    @(posedge aclk);
    vn <= cnt;
    vh <= h;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (vbusy && n < 90000);
    guard(n, 90000);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    tick(2);
    aresetn <= 1'b1;
    tick(2);
    axi_rd(OFS_CTRL, d, r);
    `CHK(d[2:0], 3'h1);
    axi_rd(8'h40, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0});
    axi_wr(OFS_RESULT, 32'h1234, r);
    `CHK(r, RESP_SLVERR);
    tick(SC + 100);
    axi_rd(OFS_IRQ_ST, d, r);
    `CHK({d[IRQ_DONE], irq}, 2'h2);
    axi_wr(OFS_IRQ_EN, 32'h7, r);
    tick(2);
    `CHK(irq, 1'b1);
    wait_done(10);
    tick(2);
    `CHK(irq, 1'b0);
    wait_done(SC + 10);
    foreach (rows[i]) begin
      send(rows[i].n, 16'h4);
      wait_done(SC + 10);
      `CHK(gap, SC * 10);
      `CHK(disp_digits, rows[i].dig);
      `CHK(disp_blank, rows[i].blank);
      `CHK(flash_v, 1'b1);
      tick(30);
      `CHK(ovf_led, 1'b0);
    end
    long_sel_in <= 1'b1;
    wait_done(SC + 10);
    axi_rd(OFS_STATUS, d, r);
    `CHK(d[ST_LONG], 1'b1);
    send(16'd10000, 16'h4);
    wait_done(LC + 10);
    `CHK(gap, LC * 10);
    `CHK(disp_digits, 16'h9999);
    `CHK({st[IRQ_OVF], flash_v}, 2'h2);
    tick(30);
    `CHK(ovf_led, 1'b1);
    k = 0;
    while (pulse_echo !== 1'b0 && k < 5000) begin
      tick(1);
      k++;
    end
    guard(k, 5000);
    send(16'd1, 16'd100);
    k = 0;
    while (pulse_echo === 1'b1 && k < 5000) begin
      tick(1);
      k++;
    end
    guard(k, 5000);
    tick(1);
    `CHK(last_w, ECHO_CYC);
    bat_low_in <= 1'b1;
    tick(10);
    `CHK(bat_led, 1'b1);
    axi_rd(OFS_IRQ_ST, d, r);
    `CHK({d[IRQ_BAT], irq}, 2'h3);
    summarize();
  end
endmodule
